// ===== hdl/xmove_pkg.sv
// Package: widths, timing, states and carriers of the external data move unit
package xmove_pkg;

	localparam int unsigned ADDR_W = 16;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned BANK_W = 2;
	localparam int unsigned IDX_W = 3;
	localparam int unsigned RF_W = BANK_W + IDX_W;
	localparam int unsigned RF_DEPTH = 32;
	localparam logic [IDX_W-1:0] IDX_ZERO = 3'h0;
	localparam logic [IDX_W-1:0] IDX_ONE = 3'h1;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [BYTE_W-1:0] BYTE_ONES = 8'hff;

	// Phases of a machine cycle, and cycles per move
	localparam int unsigned PHASES = 6;
	localparam logic [2:0] PHASE_LAST = 3'h5;
	localparam int unsigned MOVE_CYCLES = 2;
	localparam int unsigned MOVE_BYTES = 1;

	typedef enum logic [1:0] {
		MOVE_READ_IDX,
		MOVE_READ_PTR,
		MOVE_WRITE_IDX,
		MOVE_WRITE_PTR
	} move_kind_e;

	typedef enum {
		ST_IDLE,
		ST_ALE,
		ST_ADDR,
		ST_STROBE,
		ST_HOLD,
		ST_DONE
	} move_state_e;

	// Request from the core sequencer
	typedef struct packed {
		move_kind_e kind;
		logic index_sel;
		logic [BANK_W-1:0] bank;
		logic [BYTE_W-1:0] accumulator;
		logic [ADDR_W-1:0] wide_address_pointer;
	} move_req_s;

	// Pins of the external bus
	typedef struct packed {
		logic [BYTE_W-1:0] muxed_addr_data_port_out;
		logic muxed_addr_data_port_oe_n;
		logic [BYTE_W-1:0] upper_address_port_out;
		logic addr_latch_strobe;
		logic read_strobe_n;
		logic write_strobe_n;
	} ext_bus_s;

	// Index register file write port
	typedef struct packed {
		logic wr_en;
		logic [RF_W-1:0] wr_addr;
		logic [BYTE_W-1:0] wr_data;
	} rf_wr_s;

endpackage

// ===== hdl/xmove_regfile.sv
// Memory: register banks holding the index registers, registered read
module xmove_regfile
(
	// Clock
	input wire logic clk_sys,
	// Write port
	input wire xmove_pkg::rf_wr_s wr,
	// Read port
	input wire logic [xmove_pkg::RF_W-1:0] rd_addr,
	output logic [xmove_pkg::BYTE_W-1:0] rd_data
);

	logic [xmove_pkg::BYTE_W-1:0] mem [xmove_pkg::RF_DEPTH];
	logic [xmove_pkg::BYTE_W-1:0] rd_data_ff;

	always_ff @(posedge clk_sys)
	begin
		if (wr.wr_en)
		begin
			mem[wr.wr_addr] <= wr.wr_data;
		end
		rd_data_ff <= mem[rd_addr];
	end

	assign rd_data = rd_data_ff;

endmodule

// ===== hdl/xmove_unit.sv
// External data move unit: drives the multiplexed bus for byte moves
// ============================================================
// How it works
// - Pointer form drives high byte on upper port
// - Pointer low byte then data share muxed port
// - Upper port latch untouched by pointer access
// - Pointer reaches 64K with no port setup
// - Index form leaves upper port showing latch
// - Both forms reach the same paged array
// - Index form addresses 256 bytes on muxed port
// - Read and write strobes driven during move
// - Read loads accumulator; write stores accumulator
// - Index form uses register 0/1 of bank
module xmove_unit
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic sys_rst,
	// Core request
	input wire logic move_start,
	input wire xmove_pkg::move_req_s move_req,
	// Upper port latch write from core
	input wire logic port_latch_we,
	input wire logic [xmove_pkg::BYTE_W-1:0] port_latch_wdata,
	// Index register write from core
	input wire xmove_pkg::rf_wr_s idx_wr,
	// Muxed port input pins
	input wire logic [xmove_pkg::BYTE_W-1:0] muxed_addr_data_port_in,
	// External bus pins
	output xmove_pkg::ext_bus_s ext_bus,
	// Result to core
	output logic move_busy,
	output logic move_done,
	output logic acc_we,
	output logic [xmove_pkg::BYTE_W-1:0] acc_wdata,
	output logic [xmove_pkg::BYTE_W-1:0] port_latch_q
);

	// ============================================================
	// Pin synchroniser
	logic [xmove_pkg::BYTE_W-1:0] pin_meta_ff, nxt_pin_meta;
	logic [xmove_pkg::BYTE_W-1:0] pin_sync_ff, nxt_pin_sync;

	always_comb
	begin
		nxt_pin_meta = muxed_addr_data_port_in;
		nxt_pin_sync = pin_meta_ff;
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_meta_ff <= xmove_pkg::BYTE_ZERO;
			pin_sync_ff <= xmove_pkg::BYTE_ZERO;
		end
		else
		begin
			pin_meta_ff <= nxt_pin_meta;
			pin_sync_ff <= nxt_pin_sync;
		end
	end

	// ============================================================
	// Index register file
	logic [xmove_pkg::RF_W-1:0] rf_rd_addr;
	logic [xmove_pkg::BYTE_W-1:0] rf_rd_data;

	// Selected bank, register 0 or 1
	assign rf_rd_addr = {move_req.bank,
		move_req.index_sel ? xmove_pkg::IDX_ONE : xmove_pkg::IDX_ZERO};

	xmove_regfile u_regfile
	(
		.clk_sys(clk_sys),
		.wr(idx_wr),
		.rd_addr(rf_rd_addr),
		.rd_data(rf_rd_data)
	);

	// ============================================================
	// Move sequencer
	function automatic logic is_ptr(input xmove_pkg::move_kind_e k);
		is_ptr = (k == xmove_pkg::MOVE_READ_PTR) ||
			(k == xmove_pkg::MOVE_WRITE_PTR);
	endfunction

	function automatic logic is_write(input xmove_pkg::move_kind_e k);
		is_write = (k == xmove_pkg::MOVE_WRITE_IDX) ||
			(k == xmove_pkg::MOVE_WRITE_PTR);
	endfunction

	xmove_pkg::move_state_e state_ff, nxt_state;
	logic [2:0] phase_ff, nxt_phase;
	xmove_pkg::move_req_s req_ff, nxt_req;
	xmove_pkg::ext_bus_s bus_ff, nxt_bus;
	logic [xmove_pkg::BYTE_W-1:0] latch_ff, nxt_latch;
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic acc_we_ff, nxt_acc_we;
	logic [xmove_pkg::BYTE_W-1:0] acc_data_ff, nxt_acc_data;
	logic phase_end;

	assign phase_end = (phase_ff == xmove_pkg::PHASE_LAST);

	always_comb
	begin
		nxt_state = state_ff;
		nxt_phase = phase_end ? 3'h0 : phase_ff + 3'h1;
		nxt_req = req_ff;
		nxt_bus = bus_ff;
		nxt_latch = latch_ff;
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_acc_we = 1'b0;
		nxt_acc_data = acc_data_ff;
		// Latch changes only by explicit core write
		if (port_latch_we)
		begin
			nxt_latch = port_latch_wdata;
		end
		// Index form keeps the upper port on the latch
		if (!is_ptr(req_ff.kind))
		begin
			nxt_bus.upper_address_port_out = nxt_latch;
		end
		case (state_ff)
			xmove_pkg::ST_IDLE:
			begin
				nxt_phase = 3'h0;
				nxt_bus.upper_address_port_out = nxt_latch;
				if (move_start)
				begin
					nxt_req = move_req;
					nxt_busy = 1'b1;
					nxt_state = xmove_pkg::ST_ALE;
				end
			end
			xmove_pkg::ST_ALE:
			begin
				// Low address byte out with latch strobe
				if (is_ptr(req_ff.kind))
				begin
					nxt_bus.muxed_addr_data_port_out =
						req_ff.wide_address_pointer[xmove_pkg::BYTE_W-1:0];
					nxt_bus.upper_address_port_out =
						req_ff.wide_address_pointer[xmove_pkg::ADDR_W-1:
						xmove_pkg::BYTE_W];
				end
				else
				begin
					nxt_bus.muxed_addr_data_port_out = rf_rd_data;
					nxt_bus.upper_address_port_out = nxt_latch;
				end
				nxt_bus.muxed_addr_data_port_oe_n = 1'b0;
				nxt_bus.addr_latch_strobe = 1'b1;
				nxt_state = xmove_pkg::ST_ADDR;
			end
			xmove_pkg::ST_ADDR:
			begin
				// Strobe drops while address still held
				if (phase_end)
				begin
					nxt_bus.addr_latch_strobe = 1'b0;
					nxt_state = xmove_pkg::ST_STROBE;
				end
			end
			xmove_pkg::ST_STROBE:
			begin
				if (is_write(req_ff.kind))
				begin
					nxt_bus.muxed_addr_data_port_out =
						req_ff.accumulator;
					nxt_bus.write_strobe_n = 1'b0;
				end
				else
				begin
					nxt_bus.muxed_addr_data_port_out = xmove_pkg::BYTE_ONES;
					nxt_bus.muxed_addr_data_port_oe_n = 1'b1;
					nxt_bus.read_strobe_n = 1'b0;
				end
				nxt_state = xmove_pkg::ST_HOLD;
			end
			xmove_pkg::ST_HOLD:
			begin
				// Second machine cycle ends the move
				if (phase_end)
				begin
					if (!is_write(req_ff.kind))
					begin
						nxt_acc_data = pin_sync_ff;
						nxt_acc_we = 1'b1;
					end
					nxt_bus.read_strobe_n = 1'b1;
					nxt_bus.write_strobe_n = 1'b1;
					nxt_state = xmove_pkg::ST_DONE;
				end
			end
			xmove_pkg::ST_DONE:
			begin
				nxt_bus.muxed_addr_data_port_oe_n = 1'b1;
				nxt_bus.muxed_addr_data_port_out = xmove_pkg::BYTE_ONES;
				nxt_bus.upper_address_port_out = nxt_latch;
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
				nxt_state = xmove_pkg::ST_IDLE;
			end
			default:
			begin
				nxt_state = xmove_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff <= xmove_pkg::ST_IDLE;
			phase_ff <= 3'h0;
			req_ff <= '0;
			bus_ff <= '{muxed_addr_data_port_out: xmove_pkg::BYTE_ONES,
				muxed_addr_data_port_oe_n: 1'b1,
				upper_address_port_out: xmove_pkg::BYTE_ONES,
				addr_latch_strobe: 1'b0,
				read_strobe_n: 1'b1,
				write_strobe_n: 1'b1};
			latch_ff <= xmove_pkg::BYTE_ONES;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			acc_we_ff <= 1'b0;
			acc_data_ff <= xmove_pkg::BYTE_ZERO;
		end
		else
		begin
			state_ff <= nxt_state;
			phase_ff <= nxt_phase;
			req_ff <= nxt_req;
			bus_ff <= nxt_bus;
			latch_ff <= nxt_latch;
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			acc_we_ff <= nxt_acc_we;
			acc_data_ff <= nxt_acc_data;
		end
	end

	// ============================================================
	// Outputs
	assign ext_bus = bus_ff;
	assign move_busy = busy_ff;
	assign move_done = done_ff;
	assign acc_we = acc_we_ff;
	assign acc_wdata = acc_data_ff;
	assign port_latch_q = latch_ff;

endmodule

// ===== verif/xmove_ram_model.sv
// Partner: external RAM on the multiplexed bus
module xmove_ram_model
(
	// Clock and bus pins
	input wire logic clk_sys,
	input wire xmove_pkg::ext_bus_s bus,
	// Slow answer select
	input wire logic slow,
	// Resolved muxed port level
	output logic [7:0] pin
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	logic [15:0] addr;
	logic [7:0] last = 8'h00;
	logic [2:0] wt = 3'h0;
	logic drv;
	assign drv = !bus.read_strobe_n && (!slow || wt > 3'h1);
	always_comb
	begin
		if (!bus.muxed_addr_data_port_oe_n)
			pin = bus.muxed_addr_data_port_out;
		else if (drv)
			pin = mem[addr];
		else
			pin = ~last;
	end
	always @(posedge clk_sys)
	begin
		if (bus.addr_latch_strobe)
			addr <= {bus.upper_address_port_out,
				bus.muxed_addr_data_port_out};
		if (!bus.write_strobe_n)
			mem[addr] <= bus.muxed_addr_data_port_out;
		wt <= bus.read_strobe_n ? 3'h0 : wt + {2'h0, wt != 3'h7};
		last <= pin;
	end
endmodule

// ===== verif/xmove_unit_assertions.sv
// Checker: bus timing of the external data move unit
module xmove_unit_chk
(
	// Watched ports
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic move_start,
	input wire logic port_latch_we,
	input wire logic [7:0] port_latch_wdata,
	input wire xmove_pkg::ext_bus_s ext_bus,
	input wire logic move_busy,
	input wire logic move_done,
	input wire logic acc_we,
	input wire logic [7:0] port_latch_q
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	// ====
	// Checks
	a_strobe_excl: assert property (
		ext_bus.read_strobe_n || ext_bus.write_strobe_n)
		else $error("Both strobes low");
	a_ale_no_data: assert property (
		ext_bus.addr_latch_strobe
		|-> ext_bus.read_strobe_n && ext_bus.write_strobe_n)
		else $error("Latch pulse with strobe");
	a_write_drives: assert property (
		!ext_bus.write_strobe_n |-> !ext_bus.muxed_addr_data_port_oe_n)
		else $error("Write without drive");
	a_read_floats: assert property (
		!ext_bus.read_strobe_n |-> ext_bus.muxed_addr_data_port_oe_n)
		else $error("Read while driving");
	a_latch_hold: assert property (
		!port_latch_we |=> $stable(port_latch_q))
		else $error("Latch changed");
	a_latch_load: assert property (
		port_latch_we |=> port_latch_q == $past(port_latch_wdata))
		else $error("Latch not loaded");
	a_move_span: assert property (
		move_start && !move_busy |-> ##[12:14] move_done)
		else $error("Move too long");
	a_acc_then_done: assert property (
		acc_we |=> move_done)
		else $error("Result without done");
	a_idle_upper: assert property (
		!move_busy |-> ext_bus.upper_address_port_out == port_latch_q)
		else $error("Idle upper port differs from latch");
endmodule
bind xmove_unit xmove_unit_chk u_chk (.*);

// ===== verif/tb_external_data_ram_access.sv
// Testbench: external data moves against a RAM model
module tb_external_data_ram_access;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, sys_rst, move_start, port_latch_we, acc_we;
	logic move_busy, move_done, slow;
	logic [7:0] port_latch_wdata, acc_wdata, port_latch_q, rd;
	logic [7:0] muxed_addr_data_port_in;
	logic [15:0] ale;
	xmove_pkg::move_req_s move_req;
	xmove_pkg::rf_wr_s idx_wr;
	xmove_pkg::ext_bus_s ext_bus;
	int n_mismatch, checks_done;
	localparam logic [15:0] MOVE_EDGES =
		16'(xmove_pkg::MOVE_CYCLES * xmove_pkg::PHASES + 1);
	xmove_unit dut (.*);
	xmove_ram_model ram (.clk_sys, .bus(ext_bus), .slow,
		.pin(muxed_addr_data_port_in));
	// ====
	// Tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks_done++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("Error at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic results;
		if (n_mismatch == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic mv(input logic [1:0] k, input logic s,
		input logic [15:0] p, input logic [7:0] a);
		int n;
		logic seen_rd, seen_wr;
		seen_rd = 1'b0;
		seen_wr = 1'b0;
		@(posedge clk_sys);
		move_req <= {k, s, 2'h2, a, p};
		move_start <= 1'b1;
		@(posedge clk_sys);
		move_start <= 1'b0;
		@(negedge clk_sys);
		chk({15'h0, move_busy}, 16'h1);
		for (n = 0; n < 99 && move_done !== 1'b1; n++)
		begin
			@(negedge clk_sys);
			if (ext_bus.addr_latch_strobe === 1'b1)
				ale = {ext_bus.upper_address_port_out,
					ext_bus.muxed_addr_data_port_out};
			if (acc_we === 1'b1)
				rd = acc_wdata;
			if (ext_bus.read_strobe_n === 1'b0)
				seen_rd = 1'b1;
			if (ext_bus.write_strobe_n === 1'b0)
				seen_wr = 1'b1;
		end
		chk({15'h0, n < 99}, 16'h1);
		// Two machine cycles, then the registered done pulse
		chk(n[15:0], MOVE_EDGES);
		chk({15'h0, move_busy}, 16'h0);
		chk({14'h0, seen_rd, seen_wr}, {14'h0, !k[1], k[1]});
		chk({14'h0, ext_bus[1:0]}, 16'h3);
	endtask
	task automatic t_reset;
		@(posedge clk_sys);
		move_req <= {2'h3, 1'b0, 2'h2, 8'h99, 16'h4321};
		move_start <= 1'b1;
		@(posedge clk_sys);
		move_start <= 1'b0;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(negedge clk_sys);
		chk({15'h0, move_busy}, 16'h0);
		chk({14'h0, ext_bus[1:0]}, 16'h3);
		chk(ext_bus.upper_address_port_out, 8'hff);
		mv(2'h1, 1'b0, 16'hbe01, 8'h00);
		chk(ale, 16'hbe01);
		chk(rd, 8'ha5);
	endtask
	task automatic setup;
		@(posedge clk_sys);
		port_latch_we <= 1'b1;
		port_latch_wdata <= 8'h12;
		idx_wr <= {1'b1, 5'h10, 8'h34};
		@(posedge clk_sys);
		port_latch_we <= 1'b0;
		idx_wr <= {1'b1, 5'h11, 8'h56};
		@(posedge clk_sys);
		idx_wr.wr_en <= 1'b0;
	endtask
	task automatic t_ptr;
		setup();
		mv(2'h3, 1'b0, 16'hbe01, 8'ha5);
		chk(ale, 16'hbe01);
		chk(ram.mem[16'hbe01], 8'ha5);
		chk(port_latch_q, 8'h12);
		chk(ext_bus.upper_address_port_out, 8'h12);
		mv(2'h1, 1'b0, 16'hffff, 8'h00);
		chk(rd, 8'h3c);
	endtask
	task automatic t_idx;
		slow <= 1'b1;
		setup();
		mv(2'h2, 1'b0, 16'h0000, 8'h77);
		chk(ale, 16'h1234);
		chk(ram.mem[16'h1234], 8'h77);
		mv(2'h1, 1'b0, 16'h1234, 8'h00);
		chk(rd, 8'h77);
		mv(2'h0, 1'b1, 16'h0000, 8'h00);
		chk(ale, 16'h1256);
		chk(rd, 8'h5a);
	endtask
	// ====
	// Run
	initial
	begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	initial
	begin
		#(25 * 4000);
		n_mismatch++;
		results();
	end
	initial
	begin
		sys_rst = 1'b1;
		move_start = 1'b0;
		move_req = '0;
		port_latch_we = 1'b0;
		port_latch_wdata = 8'h00;
		idx_wr = '0;
		slow = 1'b0;
		ram.mem[16'hffff] = 8'h3c;
		ram.mem[16'h1256] = 8'h5a;
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		t_ptr();
		t_idx();
		t_reset();
		results();
	end
endmodule
